// >>> shared/uart_flow_pkg.sv
// Constants, register map and field layout of the flow-controlled serial port
// ============================================================================
package uart_flow_pkg;

	// ========================================================================
	// Clock and bit rate
	localparam int CLK_HZ      = 25_000_000;
	localparam int MAX_BPS     = 1_000_000;
	localparam int MIN_DIV     = (CLK_HZ + MAX_BPS - 1) / MAX_BPS;
	localparam int DEFAULT_BPS = 115_200;
	localparam logic [15:0] BAUD_RESET = 16'(CLK_HZ / DEFAULT_BPS);

	// ========================================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_BAUD      = 8'h04;
	localparam logic [7:0] REG_PINSEL    = 8'h08;
	localparam logic [7:0] REG_TXDATA    = 8'h0C;
	localparam logic [7:0] REG_STATUS    = 8'h10;
	localparam logic [7:0] REG_DMA_BASE  = 8'h14;
	localparam logic [7:0] REG_DMA_MAX   = 8'h18;
	localparam logic [7:0] REG_DMA_COUNT = 8'h1C;

	// ========================================================================
	// Control fields
	localparam int CTRL_TX_EN     = 0;
	localparam int CTRL_RX_EN     = 1;
	localparam int CTRL_FLOW_EN   = 2;
	localparam int CTRL_PARITY_EN = 3;
	localparam int CTRL_SLEEP     = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// Pin select: one byte per line, index in [4:0], connect bit 7
	localparam int SEL_TXD = 0;
	localparam int SEL_RXD = 1;
	localparam int SEL_RTS = 2;
	localparam int SEL_CTS = 3;
	localparam int SEL_CONNECT = 7;
	localparam logic [31:0] PINSEL_RESET = 32'h0000_0000;

	// Status fields; sticky ones clear on a written one
	localparam int ST_TX_FULL  = 0;
	localparam int ST_TX_BUSY  = 1;
	localparam int ST_RX_BUSY  = 2;
	localparam int ST_PAR_ERR  = 3;
	localparam int ST_FRAME    = 4;
	localparam int ST_OVERRUN  = 5;
	localparam int ST_CONFLICT = 6;
	localparam int ST_DMA_FULL = 7;
	localparam int ST_RTS_ON   = 8;

	// Line levels: handshake lines are active low, data idles high
	localparam logic LINE_IDLE = 1'b1;
	localparam logic HS_ON     = 1'b0;
	localparam logic HS_OFF    = 1'b1;

	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage : uart_flow_pkg

// >>> design/uart_flow.sv
// Four-wire serial port with handshaking, pin routing and receive memory writer
`timescale 1ns/10ps
module uart_flow
	import uart_flow_pkg::*;
#(
	parameter int NUM_PINS = 19
)
(
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                reset_n,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	// Memory write port for received bytes
	output logic                     dma_req,
	output logic      [31:0]         dma_addr,
	output logic      [7:0]          dma_data,
	input  wire logic                dma_ack,
	// General-purpose pins
	input  wire logic [NUM_PINS-1:0] gpio_in,
	input  wire logic [NUM_PINS-1:0] pin_busy,
	output logic      [NUM_PINS-1:0] gpio_out,
	output logic      [NUM_PINS-1:0] gpio_oe_n
);

	if (NUM_PINS < 1 || NUM_PINS > 32)
	begin : g_bad_pins
		$error("NUM_PINS must lie in 1..32");
	end

	// ========================================================================
	// Reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ========================================================================
	// Pin routing
	logic [4:0]  ctrl;
	logic [15:0] baud;
	logic [31:0] pinsel;
	logic [3:0]  line_ok;
	logic        rxd_in;
	logic        cts_in;
	logic        txd_line;
	logic        rts_line;

	always_comb
	begin
		logic [4:0] idx;
		idx = 5'h00;
		for (int s = 0; s < 4; s++)
		begin
			idx = pinsel[s*8 +: 5];
			line_ok[s] = pinsel[s*8 + SEL_CONNECT] && (32'(idx) < NUM_PINS)
				&& !pin_busy[idx];
			for (int t = 0; t < s; t++)
				if (line_ok[t] && pinsel[t*8 +: 5] == idx)
					line_ok[s] = 1'b0;
		end
		rxd_in = line_ok[SEL_RXD] ? gpio_in[pinsel[SEL_RXD*8 +: 5]] : LINE_IDLE;
		cts_in = line_ok[SEL_CTS] ? gpio_in[pinsel[SEL_CTS*8 +: 5]] : HS_ON;
	end

	logic [NUM_PINS-1:0] next_gpio_out;
	logic [NUM_PINS-1:0] next_gpio_oe_n;

	always_comb
	begin
		next_gpio_out  = {NUM_PINS{1'b1}};
		next_gpio_oe_n = {NUM_PINS{1'b1}};
		for (int p = 0; p < NUM_PINS; p++)
		begin
			if (line_ok[SEL_TXD] && 32'(pinsel[SEL_TXD*8 +: 5]) == p)
			begin
				next_gpio_out[p]  = txd_line;
				next_gpio_oe_n[p] = 1'b0;
			end
			else if (line_ok[SEL_RTS] && 32'(pinsel[SEL_RTS*8 +: 5]) == p)
			begin
				next_gpio_out[p]  = rts_line;
				next_gpio_oe_n[p] = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gpio_out  <= {NUM_PINS{1'b1}};
			gpio_oe_n <= {NUM_PINS{1'b1}};
		end
		else
		begin
			gpio_out  <= next_gpio_out;
			gpio_oe_n <= next_gpio_oe_n;
		end
	end

	// ========================================================================
	// Transmitter
	tx_state_t tx_state, next_tx_state;
	logic [15:0] tx_cnt, next_tx_cnt;
	logic [2:0]  tx_bit, next_tx_bit;
	logic [7:0]  tx_shift, next_tx_shift;
	logic        tx_par, next_tx_par;
	logic        next_txd_line;
	logic        tx_take;
	logic        tx_full;
	logic [7:0]  tx_hold;
	logic        tx_end;

	always_comb
	begin
		next_tx_state = tx_state;
		next_tx_cnt   = tx_cnt + 16'h0001;
		next_tx_bit   = tx_bit;
		next_tx_shift = tx_shift;
		next_tx_par   = tx_par;
		tx_take       = 1'b0;
		tx_end        = (tx_cnt >= baud - 16'h0001);
		case (tx_state)
			TX_IDLE:
			begin
				next_tx_cnt = 16'h0000;
				if (tx_full && ctrl[CTRL_TX_EN]
					&& (!ctrl[CTRL_FLOW_EN] || cts_in == HS_ON))
				begin
					tx_take       = 1'b1;
					next_tx_shift = tx_hold;
					next_tx_par   = ^tx_hold;
					next_tx_state = TX_START;
				end
			end
			TX_START:
				if (tx_end)
				begin
					next_tx_cnt   = 16'h0000;
					next_tx_bit   = 3'h0;
					next_tx_state = TX_DATA;
				end
			TX_DATA:
				if (tx_end)
				begin
					next_tx_cnt   = 16'h0000;
					next_tx_shift = {1'b0, tx_shift[7:1]};
					next_tx_bit   = tx_bit + 3'h1;
					if (tx_bit == 3'h7)
						next_tx_state = ctrl[CTRL_PARITY_EN] ? TX_PAR : TX_STOP;
				end
			TX_PAR:
				if (tx_end)
				begin
					next_tx_cnt   = 16'h0000;
					next_tx_state = TX_STOP;
				end
			TX_STOP:
				if (tx_end)
					next_tx_state = TX_IDLE;
			default:
				next_tx_state = TX_IDLE;
		endcase
		case (next_tx_state)
			TX_START: next_txd_line = 1'b0;
			TX_DATA:  next_txd_line = next_tx_shift[0];
			TX_PAR:   next_txd_line = tx_par;
			default:  next_txd_line = LINE_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state <= TX_IDLE;
			tx_cnt   <= 16'h0000;
			tx_bit   <= 3'h0;
			tx_shift <= 8'h00;
			tx_par   <= 1'b0;
			txd_line <= LINE_IDLE;
		end
		else
		begin
			tx_state <= next_tx_state;
			tx_cnt   <= next_tx_cnt;
			tx_bit   <= next_tx_bit;
			tx_shift <= next_tx_shift;
			tx_par   <= next_tx_par;
			txd_line <= next_txd_line;
		end
	end

	// ========================================================================
	// Receiver
	rx_state_t rx_state, next_rx_state;
	logic [15:0] rx_cnt, next_rx_cnt;
	logic [2:0]  rx_bit, next_rx_bit;
	logic [7:0]  rx_shift, next_rx_shift;
	logic        rx_prev;
	logic        rx_done;
	logic        par_ev;
	logic        frame_ev;
	logic        rx_end;

	always_comb
	begin
		next_rx_state = rx_state;
		next_rx_cnt   = rx_cnt + 16'h0001;
		next_rx_bit   = rx_bit;
		next_rx_shift = rx_shift;
		rx_done       = 1'b0;
		par_ev        = 1'b0;
		frame_ev      = 1'b0;
		rx_end        = (rx_cnt >= baud - 16'h0001);
		case (rx_state)
			RX_IDLE:
			begin
				next_rx_cnt = 16'h0000;
				if (ctrl[CTRL_RX_EN] && rx_prev && !rxd_in)
					next_rx_state = RX_START;
			end
			RX_START:
				if (rx_cnt >= {1'b0, baud[15:1]})
				begin
					next_rx_cnt   = 16'h0000;
					next_rx_bit   = 3'h0;
					next_rx_state = rxd_in ? RX_IDLE : RX_DATA;
				end
			RX_DATA:
				if (rx_end)
				begin
					next_rx_cnt   = 16'h0000;
					next_rx_shift = {rxd_in, rx_shift[7:1]};
					next_rx_bit   = rx_bit + 3'h1;
					if (rx_bit == 3'h7)
						next_rx_state = ctrl[CTRL_PARITY_EN] ? RX_PAR : RX_STOP;
				end
			RX_PAR:
				if (rx_end)
				begin
					next_rx_cnt   = 16'h0000;
					par_ev        = (rxd_in != ^rx_shift);
					next_rx_state = RX_STOP;
				end
			RX_STOP:
				if (rx_end)
				begin
					rx_done       = 1'b1;
					frame_ev      = !rxd_in;
					next_rx_state = RX_IDLE;
				end
			default:
				next_rx_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state <= RX_IDLE;
			rx_cnt   <= 16'h0000;
			rx_bit   <= 3'h0;
			rx_shift <= 8'h00;
			rx_prev  <= LINE_IDLE;
		end
		else
		begin
			rx_state <= next_rx_state;
			rx_cnt   <= next_rx_cnt;
			rx_bit   <= next_rx_bit;
			rx_shift <= next_rx_shift;
			rx_prev  <= rxd_in;
		end
	end

	// ========================================================================
	// Memory writer and request-to-send
	logic [31:0] dma_base;
	logic [15:0] dma_max;
	logic [15:0] dma_count, next_dma_count;
	logic        next_dma_req;
	logic [31:0] next_dma_addr;
	logic [7:0]  next_dma_data;
	logic        next_rts_line;
	logic        overrun_ev;
	logic        dma_full;

	always_comb
	begin
		next_dma_req   = dma_req;
		next_dma_addr  = dma_addr;
		next_dma_data  = dma_data;
		next_dma_count = dma_count;
		overrun_ev     = 1'b0;
		dma_full       = (dma_count >= dma_max);
		if (dma_req && dma_ack)
		begin
			next_dma_req   = 1'b0;
			next_dma_count = dma_count + 16'h0001;
		end
		if (rx_done)
		begin
			if (dma_req || dma_full)
				overrun_ev = 1'b1;
			else
			begin
				next_dma_req  = 1'b1;
				next_dma_data = rx_shift;
				next_dma_addr = dma_base + {16'h0000, dma_count};
			end
		end
		if (reg_wr && reg_addr == REG_DMA_COUNT)
			next_dma_count = 16'h0000;
		next_rts_line = (!ctrl[CTRL_RX_EN] || ctrl[CTRL_SLEEP] || dma_req
			|| dma_full || next_dma_req) ? HS_OFF : HS_ON;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dma_req   <= 1'b0;
			dma_addr  <= 32'h0000_0000;
			dma_data  <= 8'h00;
			dma_count <= 16'h0000;
			rts_line  <= HS_OFF;
		end
		else
		begin
			dma_req   <= next_dma_req;
			dma_addr  <= next_dma_addr;
			dma_data  <= next_dma_data;
			dma_count <= next_dma_count;
			rts_line  <= next_rts_line;
		end
	end

	// ========================================================================
	// Register port
	logic [4:0]  next_ctrl;
	logic [15:0] next_baud;
	logic [31:0] next_pinsel;
	logic [31:0] next_dma_base;
	logic [15:0] next_dma_max;
	logic [7:0]  next_tx_hold;
	logic        next_tx_full;
	logic [3:0]  flags, next_flags;
	logic [31:0] next_reg_rdata;
	logic [31:0] status;

	always_comb
	begin
		next_ctrl     = ctrl;
		next_baud     = baud;
		next_pinsel   = pinsel;
		next_dma_base = dma_base;
		next_dma_max  = dma_max;
		next_tx_hold  = tx_hold;
		next_tx_full  = tx_full && !tx_take;
		next_flags    = flags;
		if (reg_wr)
			case (reg_addr)
				REG_CTRL:     next_ctrl = reg_wdata[4:0];
				REG_BAUD:
					next_baud = (reg_wdata[15:0] < 16'(MIN_DIV)) ?
						16'(MIN_DIV) : reg_wdata[15:0];
				REG_PINSEL:   next_pinsel   = reg_wdata;
				REG_DMA_BASE: next_dma_base = reg_wdata;
				REG_DMA_MAX:  next_dma_max  = reg_wdata[15:0];
				REG_TXDATA:
					if (!tx_full)
					begin
						next_tx_hold = reg_wdata[7:0];
						next_tx_full = 1'b1;
					end
				REG_STATUS:   next_flags = flags & ~reg_wdata[ST_CONFLICT:ST_PAR_ERR];
				default:      next_flags = next_flags;
			endcase
		next_flags = next_flags | {|(pinsel[31:24] | pinsel[23:16] | pinsel[15:8]
			| pinsel[7:0]) && (line_ok != {pinsel[31], pinsel[23], pinsel[15], pinsel[7]}),
			overrun_ev, frame_ev, par_ev};
		status = 32'h0000_0000;
		status[ST_TX_FULL]               = tx_full;
		status[ST_TX_BUSY]               = (tx_state != TX_IDLE);
		status[ST_RX_BUSY]               = (rx_state != RX_IDLE);
		status[ST_CONFLICT:ST_PAR_ERR]   = flags;
		status[ST_DMA_FULL]              = dma_full;
		status[ST_RTS_ON]                = (rts_line == HS_ON);
		next_reg_rdata = 32'h0000_0000;
		if (reg_rd)
			case (reg_addr)
				REG_CTRL:      next_reg_rdata = {27'h0, ctrl};
				REG_BAUD:      next_reg_rdata = {16'h0, baud};
				REG_PINSEL:    next_reg_rdata = pinsel;
				REG_STATUS:    next_reg_rdata = status;
				REG_DMA_BASE:  next_reg_rdata = dma_base;
				REG_DMA_MAX:   next_reg_rdata = {16'h0, dma_max};
				REG_DMA_COUNT: next_reg_rdata = {16'h0, dma_count};
				default:       next_reg_rdata = 32'h0000_0000;
			endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl      <= CTRL_RESET;
			baud      <= BAUD_RESET;
			pinsel    <= PINSEL_RESET;
			dma_base  <= 32'h0000_0000;
			dma_max   <= 16'h0000;
			tx_hold   <= 8'h00;
			tx_full   <= 1'b0;
			flags     <= 4'h0;
			reg_rdata <= 32'h0000_0000;
		end
		else
		begin
			ctrl      <= next_ctrl;
			baud      <= next_baud;
			pinsel    <= next_pinsel;
			dma_base  <= next_dma_base;
			dma_max   <= next_dma_max;
			tx_hold   <= next_tx_hold;
			tx_full   <= next_tx_full;
			flags     <= next_flags;
			reg_rdata <= next_reg_rdata;
		end
	end

endmodule : uart_flow

// >>> verif/uart_flow_sva.sv
// Port checker for the flow-controlled serial port
`timescale 1ns/10ps
module uart_flow_sva
	import uart_flow_pkg::*;
#(
	parameter int NUM_PINS = 19,
	parameter int BIT_CYC  = 25
)
(
	// Clock and reset
	input wire logic                core_clk,
	input wire logic                reset_n,
	// Register writes
	input wire logic [7:0]          reg_addr,
	input wire logic [31:0]         reg_wdata,
	input wire logic                reg_wr,
	// Memory port
	input wire logic                dma_req,
	input wire logic [31:0]         dma_addr,
	input wire logic [7:0]          dma_data,
	input wire logic                dma_ack,
	// Pins
	input wire logic [NUM_PINS-1:0] gpio_in,
	input wire logic [NUM_PINS-1:0] gpio_out,
	input wire logic [NUM_PINS-1:0] gpio_oe_n
);
	logic [4:0]  ctrl;
	logic        prev_txd;
	logic        seen;
	int          run_len;
	logic [31:0] next_addr;
	// ========================================
	// Shadow control and transmit run length
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl      <= CTRL_RESET;
			prev_txd  <= LINE_IDLE;
			run_len   <= 0;
			seen      <= 1'b0;
			next_addr <= 32'h0;
		end
		else
		begin
			prev_txd <= gpio_out[0];
			run_len  <= (gpio_out[0] != prev_txd) ? 1 : run_len + 1;
			if (reg_wr && reg_addr == REG_CTRL)
				ctrl <= reg_wdata[4:0];
			if (dma_req && dma_ack)
			begin
				seen      <= 1'b1;
				next_addr <= dma_addr + 32'h1;
			end
		end
	end
	// ========================================
	// Properties
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	property p_low_run;
		!gpio_oe_n[0] && !prev_txd && gpio_out[0]
			|-> run_len % BIT_CYC == 0 && run_len <= 10 * BIT_CYC;
	endproperty
	a_low_run: assert property (p_low_run) else $error("txd low run off grid");
	property p_stop_gap;
		!gpio_oe_n[0] && prev_txd && !gpio_out[0] |-> run_len >= BIT_CYC;
	endproperty
	a_stop_gap: assert property (p_stop_gap) else $error("txd high run short");
	property p_cts_hold;
		(ctrl[CTRL_FLOW_EN] && gpio_in[3] == HS_OFF) [*5] ##0
			(prev_txd && run_len > 11 * BIT_CYC) |-> gpio_out[0];
	endproperty
	a_cts_hold: assert property (p_cts_hold) else $error("frame began on cts off");
	property p_rts_off;
		(!ctrl[CTRL_RX_EN] || ctrl[CTRL_SLEEP]) [*3] ##0 !gpio_oe_n[2]
			|-> gpio_out[2] == HS_OFF;
	endproperty
	a_rts_off: assert property (p_rts_off) else $error("rts on while rx idle");
	property p_rts_pend;
		dma_req [*2] ##0 !gpio_oe_n[2] |-> gpio_out[2] == HS_OFF;
	endproperty
	a_rts_pend: assert property (p_rts_pend) else $error("rts on with byte pending");
	property p_dma_hold;
		dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_data);
	endproperty
	a_dma_hold: assert property (p_dma_hold) else $error("memory request dropped");
	property p_dma_done;
		dma_req && dma_ack |=> !dma_req;
	endproperty
	a_dma_done: assert property (p_dma_done) else $error("memory request stuck");
	property p_dma_seq;
		$rose(dma_req) && seen |-> dma_addr == next_addr;
	endproperty
	a_dma_seq: assert property (p_dma_seq) else $error("memory address skipped");
endmodule : uart_flow_sva

bind uart_flow uart_flow_sva #(.NUM_PINS(NUM_PINS), .BIT_CYC(25)) chk (
	.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .dma_req(dma_req),
	.dma_addr(dma_addr), .dma_data(dma_data), .dma_ack(dma_ack),
	.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n)
);

// >>> verif/serial_partner.sv
// Far-side serial model: frame sender, frame catcher, clear-to-send driver
`timescale 1ns/10ps
module serial_partner
	import uart_flow_pkg::*;
#(
	parameter int BIT_CYC = 25
)
(
	// Clock
	input  wire logic core_clk,
	// Lines
	input  wire logic txd,
	input  wire logic rts,
	output logic      rxd,
	output logic      cts,
	// Bench control
	input  wire logic par_en,
	input  wire logic hold
);
	logic [9:0] caught[$];
	logic [9:0] w;
	assign cts = hold ? HS_OFF : HS_ON;
	initial rxd = LINE_IDLE;
	// Waits a bounded time for request-to-send ON before sending
	task automatic send(input logic [7:0] b, input logic par, input logic stp);
		int n;
		logic [10:0] f;
		f = {stp, par, b, 1'b0};
		for (n = 0; n < 2000 && rts != HS_ON; n++)
			@(posedge core_clk);
		if (n == 2000)
		begin
			testbench.fails++;
			testbench.close_out();
		end
		for (int k = 0; k < (par_en ? 11 : 10); k++)
		begin
			rxd <= (k == 9 && !par_en) ? stp : f[k];
			repeat (BIT_CYC) @(posedge core_clk);
		end
		rxd <= LINE_IDLE;
	endtask : send
	// ========================================
	// Catcher samples mid-bit, keeps {stop, parity, data}
	always
	begin
		@(negedge txd);
		w = 10'h0;
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int k = 0; k < (par_en ? 10 : 9); k++)
		begin
			repeat (BIT_CYC) @(posedge core_clk);
			w = {txd, w[9:1]};
		end
		caught.push_back(par_en ? w : {w[9], 1'b0, w[8:1]});
	end
endmodule : serial_partner

// >>> verif/testbench.sv
// Self-checking bench for the flow-controlled serial port
`timescale 1ns/10ps
module testbench
	import uart_flow_pkg::*;
;
	localparam int BC = 25;
	logic        core_clk = 1'b0;
	logic        reset_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        dma_req;
	logic [31:0] dma_addr;
	logic [7:0]  dma_data;
	logic        dma_ack = 1'b0;
	logic [18:0] gpio_in;
	logic [18:0] pin_busy;
	logic [18:0] gpio_out;
	logic [18:0] gpio_oe_n;
	logic        rxd;
	logic        cts;
	logic        hold;
	logic        par_en;
	logic [31:0] v;
	logic [39:0] mem_q[$];
	logic [7:0]  rxb[4] = '{8'h5A, 8'hC3, 8'h01, 8'h02};
	int          ack_wait = 0;
	int          fails = 0;
	int          checks_done = 0;
	always #20 core_clk = ~core_clk;
	assign gpio_in = {15'h7FFF, cts, 1'b1, rxd, 1'b1};
	uart_flow DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.dma_req(dma_req), .dma_addr(dma_addr), .dma_data(dma_data), .dma_ack(dma_ack),
		.gpio_in(gpio_in), .pin_busy(pin_busy), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
	serial_partner #(.BIT_CYC(BC)) peer (.core_clk(core_clk), .txd(gpio_out[0]),
		.rts(gpio_out[2]), .rxd(rxd), .cts(cts), .par_en(par_en), .hold(hold));
	// ========================================
	// Slow memory: accepts each byte after four waiting cycles, on the fifth cycle of its request
	always @(posedge core_clk)
	begin
		if (dma_req && dma_ack)
			mem_q.push_back({dma_addr, dma_data});
		ack_wait <= dma_req ? ack_wait + 1 : 0;
		dma_ack  <= dma_req && !dma_ack && ack_wait == 3;
	end
	// ========================================
	// Access and compare tasks
	task automatic close_out;
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		v = reg_rdata;
		if (m != 32'h0)
			cmp(v & m, e);
	endtask : rdc
	task automatic wait_n(input int n, input logic mem);
		int k;
		for (k = 0; k < 3000; k++)
		begin
			if ((mem ? mem_q.size() : peer.caught.size()) >= n)
				break;
			@(posedge core_clk);
		end
		if (k == 3000)
		begin
			fails++;
			close_out();
		end
	endtask : wait_n
	task automatic txchk(input logic [7:0] b, input logic p);
		wait_n(1, 1'b0);
		cmp(32'(peer.caught.pop_front()), {22'h0, 1'b1, p & ^b, b});
	endtask : txchk
	// ========================================
	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pin_busy = 19'h0;
		hold = 1'b0;
		par_en = 1'b0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rdc(REG_CTRL, 32'hFFFF_FFFF, 32'h0);
		rdc(REG_BAUD, 32'hFFFF_FFFF, {16'h0, BAUD_RESET});
		rdc(REG_PINSEL, 32'hFFFF_FFFF, PINSEL_RESET);
		rdc(8'h24, 32'hFFFF_FFFF, 32'h0);
		wr(REG_BAUD, 32'h0000_000A);
		rdc(REG_BAUD, 32'hFFFF_FFFF, 32'(MIN_DIV));
		wr(REG_PINSEL, 32'h8382_8180);
		wr(REG_DMA_BASE, 32'h0000_0100);
		wr(REG_DMA_MAX, 32'h0000_0004);
		repeat (4) @(posedge core_clk);
		cmp(32'(gpio_oe_n), 32'h0007_FFFA);
		cmp(32'(gpio_out[0]), 32'h1);
		for (int p = 0; p < 2; p++)
		begin
			// Let the previous stop bit finish so the first byte is taken at once
			repeat (BC) @(posedge core_clk);
			par_en <= p[0];
			wr(REG_CTRL, {28'h0, p[0], 3'h3});
			wr(REG_TXDATA, 32'h0000_00A5);
			rdc(REG_STATUS, 32'h0000_0003, 32'h0000_0002);
			wr(REG_TXDATA, 32'h0000_0007);
			txchk(8'hA5, p[0]);
			txchk(8'h07, p[0]);
		end
		par_en <= 1'b0;
		hold <= 1'b1;
		wr(REG_CTRL, 32'h0000_0007);
		wr(REG_TXDATA, 32'h0000_0033);
		repeat (15 * BC) @(posedge core_clk);
		cmp(32'(peer.caught.size()), 32'h0);
		hold <= 1'b0;
		txchk(8'h33, 1'b0);
		wr(REG_TXDATA, 32'h0000_0044);
		repeat (3 * BC) @(posedge core_clk);
		hold <= 1'b1;
		txchk(8'h44, 1'b0);
		wr(REG_CTRL, 32'h0000_0003);
		wr(REG_TXDATA, 32'h0000_0055);
		txchk(8'h55, 1'b0);
		hold <= 1'b0;
		cmp(32'(gpio_out[2]), 32'(HS_ON));
		peer.send(rxb[0], 1'b0, 1'b1);
		peer.send(rxb[1], 1'b0, 1'b1);
		par_en <= 1'b1;
		wr(REG_CTRL, 32'h0000_000B);
		peer.send(rxb[2], 1'b0, 1'b1);
		peer.send(rxb[3], 1'b1, 1'b0);
		wait_n(4, 1'b1);
		for (int j = 0; j < 4; j++)
		begin
			cmp(mem_q[j][39:8], 32'h100 + 32'(j));
			cmp({24'h0, mem_q[j][7:0]}, {24'h0, rxb[j]});
		end
		rdc(REG_STATUS, 32'h0000_0198, 32'h0000_0098);
		cmp(32'(gpio_out[2]), 32'(HS_OFF));
		rdc(REG_DMA_COUNT, 32'h0000_FFFF, 32'h4);
		wr(REG_STATUS, 32'h0000_0018);
		rdc(REG_STATUS, 32'h0000_0018, 32'h0);
		wr(REG_DMA_MAX, 32'h0000_0010);
		repeat (4) @(posedge core_clk);
		cmp(32'(gpio_out[2]), 32'(HS_ON));
		wr(REG_CTRL, 32'h0000_001B);
		repeat (4) @(posedge core_clk);
		cmp(32'(gpio_out[2]), 32'(HS_OFF));
		wr(REG_DMA_COUNT, 32'h0000_0000);
		rdc(REG_DMA_COUNT, 32'h0000_FFFF, 32'h0);
		pin_busy <= 19'h00020;
		wr(REG_PINSEL, 32'h8382_8185);
		rdc(REG_STATUS, 32'h0000_0040, 32'h0000_0040);
		cmp(32'(gpio_oe_n[5]), 32'h1);
		close_out();
	end
endmodule : testbench
